//--- design/pid_loop_defs.svh
`ifndef PID_LOOP_DEFS_SVH
`define PID_LOOP_DEFS_SVH
// ==========================================
// register indices, byte address = 4 * index
`define IDX_MODE      8'h00
`define IDX_SETPOINT  8'h02
`define IDX_PROCESS   8'h03
`define IDX_BIAS      8'h04
`define IDX_OUTPUT    8'h05
`define IDX_RUN       8'h06
`define IDX_PGAIN     8'h10
`define IDX_IGAIN     8'h11
`define IDX_DGAIN     8'h12
`define IDX_DLIMIT    8'h25
// ==========================================
// field positions
`define MODE_INVERT_BIT  4
`define MODE_DLIM_BIT    9
`define MODE_FREEZE_BIT  10
`define RUN_AUTO_BIT     0
`define IGAIN_MIN_BIT    15
// ==========================================
// codes and limits
`define GAIN_OFF      16'h0000
`define IGAIN_INF     16'h9999
`define DLIMIT_MAX    16'h0020
`define OUT_MAX       32'sd4095
`define OUT_MIN       32'sd0
`define SEC_PER_MIN   64'sd60
`define US_PER_CSEC   64'sd10000
`define UNITY_GAIN    14'd100
// ==========================================
// timing
`define CLK_MHZ          100
`define SAMPLE_TIME_US   1000
`define SAMPLE_CYCLES    (`SAMPLE_TIME_US * `CLK_MHZ)
`endif

//--- design/pid_loop_pkg.sv
package pid_loop_pkg;
    // ==========================================
    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // ==========================================
    // whole state of the engine except the calc_done pulse register
    typedef struct packed {
        logic [15:0]        mode;
        logic [15:0]        setpoint;
        logic [15:0]        process_variable;
        logic [15:0]        bias;
        logic [15:0]        out;
        logic [15:0]        initial_output;
        logic               auto_on;
        logic               auto_q;
        logic               first;
        logic [15:0]        pgain;
        logic [15:0]        igain;
        logic [15:0]        dgain;
        logic [15:0]        dlimit;
        logic signed [16:0] err_prev;
        logic [31:0]        tick;
        logic [31:0]        rdata;
        logic               rerr;
    } state_t;
endpackage : pid_loop_pkg

//--- design/pid_loop_term_engine.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "pid_loop_defs.svh"

// Summary of operation
// - one error value feeds all terms
// - output is sum of three terms
// - proportional term new, zero at zero error
// - integrator sums errors from auto entry
// - derivative uses error minus previous error
// - gains are four BCD digits, xx.xx
// - integral unit bit: seconds or minutes
// - proportional code 0000 removes P
// - integral 0000 or 9999 removes I
// - derivative code 0000 removes D
// - integral code acts reciprocally
// - mode bit 9 enables derivative limit
// - derivative limit 0..20 BCD, used when enabled
// - bias written back after each calculation unless frozen
// - bias is integral plus initial output
// - mode bit 10 freezes bias when saturated
// - freeze only at full range ends
// - software bias writes always accepted
// - inverted setting for reverse-acting loops
// - gain changes used from next calculation
// - error is setpoint minus process variable
// - mode bit 4 inverts output direction
module pid_loop_term_engine #(
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter int SAMPLE_US     = `SAMPLE_TIME_US
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire pid_loop_pkg::apb_req_t apb_req,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [15:0]               control_output,
    output logic                      calc_done
);

    // ==========================================
    // bcd and clamp helpers
    function automatic logic bcd_ok(input logic [15:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (v[i*4 +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : bcd_ok

    function automatic logic [13:0] bcd_bin(input logic [15:0] v);
        logic [13:0] r;
        r = 14'd0;
        for (int i = 3; i >= 0; i--) begin
            r = 14'(r * 14'd10 + 14'(v[i*4 +: 4]));
        end
        return r;
    endfunction : bcd_bin

    function automatic logic signed [63:0] clamp(input logic signed [63:0] v,
                                                  input logic signed [63:0] lim);
        logic signed [63:0] r;
        r = v;
        if (v > lim) begin
            r = lim;
        end else if (v < -lim) begin
            r = -lim;
        end
        return r;
    endfunction : clamp

    pid_loop_pkg::state_t s_r;
    pid_loop_pkg::state_t s_nxt;

    // ==========================================
    // apb decode
    logic       setup;
    logic       wr_en;
    logic [7:0] idx;
    logic       hit;

    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign idx   = apb_req.paddr[9:2];

    // zero-wait slave, answer in access phase
    assign pready  = 1'b1;
    assign pslverr = apb_req.psel & apb_req.penable & s_r.rerr;
    assign prdata  = s_r.rdata;
    assign control_output = s_r.out;

    always_comb begin
        case (idx)
            `IDX_MODE, `IDX_SETPOINT, `IDX_PROCESS, `IDX_BIAS, `IDX_OUTPUT,
            `IDX_RUN, `IDX_PGAIN, `IDX_IGAIN, `IDX_DGAIN, `IDX_DLIMIT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ==========================================
    // term arithmetic
    logic signed [16:0] err;
    logic signed [16:0] err_raw;
    logic signed [16:0] derr;
    logic [13:0]        kp;
    logic [13:0]        kc;
    logic [13:0]        ti;
    logic [13:0]        td;
    logic [13:0]        dl;
    logic               i_on;
    logic signed [63:0] p_term;
    logic signed [63:0] i_delta;
    logic signed [63:0] d_term;
    logic signed [63:0] d_free;
    logic signed [63:0] d_lim;
    logic signed [63:0] ti_us;
    logic signed [63:0] bias_new;
    logic signed [63:0] out_sum;
    logic signed [63:0] out_sat;
    logic               saturated;
    logic               calc;
    logic               freeze;
    logic signed [63:0] bias_use;
    logic signed [63:0] kp_s;
    logic signed [63:0] kc_s;
    logic signed [63:0] ti_s;
    logic signed [63:0] td_s;
    logic signed [63:0] dl_s;
    logic signed [63:0] err_s;
    logic signed [63:0] derr_s;
    logic signed [63:0] derr_abs;
    logic signed [63:0] unit_s;
    logic [15:0]        ti_code;

    // error and direction, shared by all three terms
    always_comb begin
        err_raw = $signed({1'b0, s_r.setpoint}) - $signed({1'b0, s_r.process_variable});
        err = s_r.mode[`MODE_INVERT_BIT] ? -err_raw : err_raw;
        // first calculation after auto entry has no history
        derr = s_r.first ? 17'sd0 : 17'(err - s_r.err_prev);
        err_s = 64'(err);
        derr_s = 64'(derr);
        derr_abs = (derr < 17'sd0) ? -derr_s : derr_s;
    end

    // gain words to binary
    always_comb begin
        ti_code = {1'b0, s_r.igain[14:0]}; // top bit is the unit select
        kp = bcd_bin(s_r.pgain);
        // unity loop gain keeps i and d alive when p is off
        kc = (s_r.pgain == `GAIN_OFF) ? `UNITY_GAIN : kp;
        ti = bcd_bin(ti_code);
        td = bcd_bin(s_r.dgain);
        dl = bcd_bin(s_r.dlimit);
        // signed copies, so negative errors divide correctly
        kp_s = $signed(64'(kp));
        kc_s = $signed(64'(kc));
        ti_s = $signed(64'(ti));
        td_s = $signed(64'(td));
        dl_s = $signed(64'(dl));
        unit_s = s_r.igain[`IGAIN_MIN_BIT] ? `SEC_PER_MIN : 64'sd1;
    end

    // proportional term, dropped by code 0000
    always_comb begin
        if (s_r.pgain == `GAIN_OFF) begin
            p_term = 64'sd0;
        end else begin
            p_term = (err_s * kp_s) / 64'sd100;
        end
    end

    // integral increment, reciprocal in the gain time
    always_comb begin
        i_on = (ti_code != `GAIN_OFF) && (s_r.igain != `IGAIN_INF);
        // minute unit stretches the gain time sixty-fold
        ti_us = ti_s * `US_PER_CSEC * unit_s;
        if (i_on) begin
            i_delta = (err_s * kc_s * 64'(SAMPLE_US)) / (ti_us * 64'sd100);
        end else begin
            i_delta = 64'sd0;
        end
    end

    // derivative term with optional symmetric limit
    always_comb begin
        d_free = (derr_s * kc_s * td_s * 64'sd100) / 64'(SAMPLE_US);
        // limit scales with the present change of error
        d_lim = clamp(d_free, (dl_s * kc_s * derr_abs) / 64'sd100);
        if (s_r.dgain == `GAIN_OFF) begin
            d_term = 64'sd0;
        end else if (s_r.mode[`MODE_DLIM_BIT]) begin
            d_term = d_lim;
        end else begin
            d_term = d_free;
        end
    end

    // freeze looks only at full range ends
    assign saturated = (s_r.out == 16'(`OUT_MAX)) || (s_r.out == 16'(`OUT_MIN));
    assign freeze = s_r.mode[`MODE_FREEZE_BIT] && saturated;
    // no calculation in manual, not even on the cycle auto drops
    assign calc = s_r.auto_on && s_r.auto_q && (s_r.tick == 32'(SAMPLE_CYCLES - 1));

    // bias moves by the integral step unless frozen
    always_comb begin
        bias_new = 64'($signed({1'b0, s_r.bias})) + i_delta;
        if (bias_new > `OUT_MAX) begin
            bias_new = `OUT_MAX;
        end else if (bias_new < `OUT_MIN) begin
            bias_new = `OUT_MIN;
        end
        // a frozen bias still feeds the output at its held value
        if (freeze) begin
            bias_use = 64'($signed({1'b0, s_r.bias}));
        end else begin
            bias_use = bias_new;
        end
    end

    // output is the sum of the three terms
    always_comb begin
        out_sum = p_term + d_term + bias_use;
        // clamp to the unipolar full range
        if (out_sum > `OUT_MAX) begin
            out_sat = `OUT_MAX;
        end else if (out_sum < `OUT_MIN) begin
            out_sat = `OUT_MIN;
        end else begin
            out_sat = out_sum;
        end
    end

    // ==========================================
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.auto_q = s_r.auto_on;
        s_nxt.rerr = 1'b0;
        s_nxt.tick = (s_r.tick == 32'(SAMPLE_CYCLES - 1)) ? 32'h0000_0000
                                                           : s_r.tick + 32'h0000_0001;
        // entry into auto captures output
        if (s_r.auto_on && !s_r.auto_q) begin
            s_nxt.initial_output = s_r.out;
            s_nxt.bias = s_r.out;
            s_nxt.first = 1'b1;
            s_nxt.tick = 32'h0000_0000;
        end
        // one calculation per sample
        if (calc) begin
            s_nxt.out = 16'(out_sat);
            s_nxt.err_prev = err;
            s_nxt.first = 1'b0;
            // frozen bias keeps its value at the range ends
            if (!freeze) begin
                s_nxt.bias = 16'(bias_new);
            end
        end
        // read data latched in setup
        if (setup && !apb_req.pwrite) begin
            s_nxt.rerr = ~hit;
            case (idx)
                `IDX_MODE:     s_nxt.rdata = {16'h0000, s_r.mode};
                `IDX_SETPOINT: s_nxt.rdata = {16'h0000, s_r.setpoint};
                `IDX_PROCESS:  s_nxt.rdata = {16'h0000, s_r.process_variable};
                `IDX_BIAS:     s_nxt.rdata = {16'h0000, s_r.bias};
                `IDX_OUTPUT:   s_nxt.rdata = {16'h0000, s_r.out};
                `IDX_RUN:      s_nxt.rdata = {31'h0000_0000, s_r.auto_on};
                `IDX_PGAIN:    s_nxt.rdata = {16'h0000, s_r.pgain};
                `IDX_IGAIN:    s_nxt.rdata = {16'h0000, s_r.igain};
                `IDX_DGAIN:    s_nxt.rdata = {16'h0000, s_r.dgain};
                `IDX_DLIMIT:   s_nxt.rdata = {16'h0000, s_r.dlimit};
                default:       s_nxt.rdata = 32'h0000_0000;
            endcase
        end else if (setup) begin
            s_nxt.rerr = ~hit;
        end
        // writes take effect in access phase
        if (wr_en) begin
            case (idx)
                `IDX_MODE:     s_nxt.mode = apb_req.pwdata[15:0];
                `IDX_SETPOINT: s_nxt.setpoint = apb_req.pwdata[15:0];
                `IDX_PROCESS:  s_nxt.process_variable = apb_req.pwdata[15:0];
                `IDX_BIAS:     s_nxt.bias = apb_req.pwdata[15:0];
                `IDX_OUTPUT: begin
                    if (!s_r.auto_on) begin
                        s_nxt.out = apb_req.pwdata[15:0];
                    end
                end
                `IDX_RUN:      s_nxt.auto_on = apb_req.pwdata[`RUN_AUTO_BIT];
                `IDX_PGAIN: begin
                    if (bcd_ok(apb_req.pwdata[15:0])) begin
                        s_nxt.pgain = apb_req.pwdata[15:0];
                    end
                end
                `IDX_IGAIN: begin
                    // top bit is the unit, the rest must be bcd
                    if (bcd_ok({1'b0, apb_req.pwdata[14:0]})) begin
                        s_nxt.igain = apb_req.pwdata[15:0];
                    end
                end
                `IDX_DGAIN: begin
                    if (bcd_ok(apb_req.pwdata[15:0])) begin
                        s_nxt.dgain = apb_req.pwdata[15:0];
                    end
                end
                `IDX_DLIMIT: begin
                    if (bcd_ok(apb_req.pwdata[15:0]) &&
                        apb_req.pwdata[15:0] <= `DLIMIT_MAX) begin
                        s_nxt.dlimit = apb_req.pwdata[15:0];
                    end
                end
                default: s_nxt.rerr = s_r.rerr;
            endcase
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // one-cycle pulse per calculation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calc_done <= 1'b0;
        end else begin
            calc_done <= calc;
        end
    end

endmodule : pid_loop_term_engine

//--- tb/actuator_model.sv
`timescale 1ns/1ns
module actuator_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] control_output,
    input  wire logic        calc_done,
    output logic [15:0]      held,
    output int               calc_count
);
    // take each fresh output as the actuator demand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held       <= 16'h0000;
            calc_count <= 0;
        end else if (calc_done) begin
            held       <= control_output;
            calc_count <= calc_count + 1;
        end
    end
endmodule : actuator_model

//--- tb/pid_loop_term_engine_sva.sv
`timescale 1ns/1ns
module pid_loop_term_engine_sva #(
    parameter int SAMPLE_CYCLES = 20
) (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire pid_loop_pkg::apb_req_t apb_req,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [15:0]            control_output,
    input wire logic                   calc_done
);
    localparam int LO = SAMPLE_CYCLES - 9;
    localparam int HI = SAMPLE_CYCLES - 3;
    logic acc, wr, unm, wr_out, auto_r;
    // bus phase decode
    assign acc    = apb_req.psel && apb_req.penable;
    assign wr     = acc && apb_req.pwrite;
    assign unm    = apb_req.paddr == 12'h0fc;
    assign wr_out = wr && apb_req.paddr == 12'h014;
    // run bit as last written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) auto_r <= 1'b0;
        else if (wr && apb_req.paddr == 12'h018) auto_r <= apb_req.pwdata[0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_range; control_output <= 16'h0fff; endproperty
    a_range: assert property (p_range) else $error("output past range");
    property p_pulse; calc_done |=> !calc_done; endproperty
    a_pulse: assert property (p_pulse) else $error("long done");
    property p_gap; calc_done |=> !calc_done [*8]; endproperty
    a_gap: assert property (p_gap) else $error("calcs too close");
    property p_manual; !auto_r && !$past(auto_r, 2) |-> !calc_done; endproperty
    a_manual: assert property (p_manual) else $error("calc in manual");
    property p_first; $rose(auto_r) |-> !calc_done [*8] ##[LO:HI] calc_done; endproperty
    a_first: assert property (p_first) else $error("first calc late");
    property p_held; $changed(control_output) && !$past(wr_out) |-> ##[0:2] calc_done; endproperty
    a_held: assert property (p_held) else $error("output moved alone");
    property p_gain;
        acc && apb_req.paddr == 12'h040 |-> pready && !pslverr &&
            (apb_req.pwrite || (prdata[3:0] <= 4'h9 && prdata[7:4] <= 4'h9 &&
             prdata[11:8] <= 4'h9 && prdata[15:12] <= 4'h9 && prdata[31:16] == 16'h0000));
    endproperty
    a_gain: assert property (p_gain) else $error("gain access error");
    property p_unm; acc && unm && !apb_req.pwrite |-> pslverr && prdata == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    c_calc: cover property (calc_done);
    c_auto: cover property ($rose(auto_r));
    c_unm: cover property (acc && unm);
endmodule : pid_loop_term_engine_sva
bind pid_loop_term_engine pid_loop_term_engine_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_sva (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .control_output(control_output), .calc_done(calc_done)
);

//--- tb/pid_loop_term_engine_tb_top.sv
`timescale 1ns/1ns
module pid_loop_term_engine_tb_top;
    typedef struct packed {
        logic [15:0] sp;
        logic [15:0] pv;
        logic [15:0] kp;
        logic [15:0] mode;
        logic [15:0] out;
    } row_t;
    logic                   pclk;
    logic                   presetn;
    pid_loop_pkg::apb_req_t req;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [15:0]            control_output;
    logic                   calc_done;
    logic [15:0]            held;
    int                     calc_count;
    int                     bad_count;
    int                     compares;
    row_t                   rows [7];
    pid_loop_term_engine #(.SAMPLE_CYCLES(20), .SAMPLE_US(1000)) dut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .control_output(control_output), .calc_done(calc_done));
    actuator_model act (
        .pclk(pclk), .presetn(presetn), .control_output(control_output),
        .calc_done(calc_done), .held(held), .calc_count(calc_count));
    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
                        output logic [31:0] r);
        int n;
        req.psel   <= 1'b1;
        req.pwrite <= w;
        req.paddr  <= a;
        req.pwdata <= {16'h0000, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            tally_and_finish();
        end
        r = prdata;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 16'h0000, r);
        check(r[15:0], exp);
    endtask : rd
    // manual output, inputs, then auto entry
    task automatic start(input logic [15:0] mode, o, sp, pv);
        wr(12'h018, 16'h0000);
        wr(12'h000, mode);
        wr(12'h014, o);
        wr(12'h008, sp);
        wr(12'h00c, pv);
        wr(12'h018, 16'h0001);
    endtask : start
    task automatic wait_calc(input logic [15:0] exp);
        int c0;
        int n;
        c0 = calc_count;
        n = 0;
        while (calc_count == c0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (calc_count == c0) begin
            bad_count++;
            tally_and_finish();
        end
        check(held, exp);
    endtask : wait_calc
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        bad_count = 0;
        compares = 0;
        rows = '{
            '{16'h03e8, 16'h0320, 16'h0250, 16'h0000, 16'h0258},
            '{16'h03e8, 16'h0320, 16'h0250, 16'h0010, 16'h0000},
            '{16'h03e8, 16'h0320, 16'h0000, 16'h0000, 16'h0064},
            '{16'h02bc, 16'h02bc, 16'h0250, 16'h0000, 16'h0064},
            '{16'h0fa0, 16'h0000, 16'h9999, 16'h0000, 16'h0fff},
            '{16'h01f4, 16'h0226, 16'h0100, 16'h0010, 16'h0096},
            '{16'h0258, 16'h01f4, 16'h00a0, 16'h0000, 16'h00c8}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wr(12'h044, 16'h9999);
        wr(12'h048, 16'h0000);
        foreach (rows[i]) begin
            wr(12'h040, rows[i].kp);
            start(rows[i].mode, 16'h0064, rows[i].sp, rows[i].pv);
            wait_calc(rows[i].out);
            rd(12'h010, 16'h0064);
        end
        rd(12'h040, 16'h0100);
        $display("table done");
        wr(12'h040, 16'h0000);
        wr(12'h044, 16'h0001);
        start(16'h0000, 16'h0064, 16'h03e8, 16'h0000);
        wait_calc(16'h00c8);
        wait_calc(16'h012c);
        rd(12'h010, 16'h012c);
        wr(12'h044, 16'h0002);
        wait_calc(16'h015e);
        wr(12'h044, 16'h8001);
        wait_calc(16'h015f);
        $display("integral done");
        wr(12'h044, 16'h0001);
        start(16'h0400, 16'h0032, 16'h0000, 16'h03e8);
        wait_calc(16'h0000);
        wr(12'h008, 16'h03e8);
        wr(12'h00c, 16'h0000);
        wait_calc(16'h0000);
        wr(12'h010, 16'h01f4);
        rd(12'h010, 16'h01f4);
        wait_calc(16'h01f4);
        wait_calc(16'h0258);
        $display("freeze done");
        wr(12'h044, 16'h9999);
        wr(12'h094, 16'h0005);
        wr(12'h048, 16'h0001);
        start(16'h0200, 16'h0064, 16'h01f4, 16'h01f4);
        wait_calc(16'h0064);
        wr(12'h00c, 16'h01ea);
        wait_calc(16'h0096);
        wait_calc(16'h0064);
        wr(12'h000, 16'h0000);
        wr(12'h00c, 16'h01e0);
        wait_calc(16'h00c8);
        $display("derivative done");
        rd(12'h0fc, 16'h0000);
        presetn <= 1'b0;
        @(posedge pclk);
        check(control_output, 16'h0000);
        presetn <= 1'b1;
        rd(12'h040, 16'h0000);
        $display("reset done");
        tally_and_finish();
    end
endmodule : pid_loop_term_engine_tb_top
